// *** core/eld_dispatch_check.sv ***
// Front-end checks of the privileged and user-level enclave instructions,
// with a classic Wishbone slave holding feature, bitmap and leaf settings.
// Assumes one core clock, synchronous inputs and a single request in flight.
`timescale 1ns/10ps
`include "eld_map.svh"
module eld_dispatch_check (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Instruction request from decode
    input wire logic req_valid_i,
    input wire eld_pkg::eld_instr_t instr_i,
    input wire eld_pkg::eld_mode_t mode_i,
    output logic req_ready_o,
    // Outcome to exception delivery
    output logic res_valid_o,
    output eld_pkg::eld_result_t result_o
);
    import eld_pkg::*;

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // True when a leaf number falls in a 32-entry class mask
    function automatic logic leaf_in(input logic [31:0] leaf, input logic [31:0] mask);
        logic hit;
        hit = 1'b0;
        if (leaf < `ELD_LEAF_LIMIT) begin
            hit = mask[leaf[4:0]];
        end
        return hit;
    endfunction

    // Width of addresses and operands; the default-size bit plays no part
    function automatic logic in_64bit(input eld_mode_t m);
        return m.long_mode_active & m.cs_long;
    endfunction

    // Register file
    logic [31:0] ctrl_q;
    logic [31:0] exit_lo_q;
    logic [31:0] exit_hi_q;
    logic [31:0] priv_leaves_q;
    logic [31:0] user_leaves_q;
    logic [31:0] status_q;
    logic [31:0] rd_data_d;
    logic [31:0] wb_dat_q;
    logic wb_ack_q;
    logic wr_fire;
    logic acc_fire;

    // Request path
    eld_state_t state_q;
    eld_state_t state_d;
    eld_instr_t instr_q;
    eld_mode_t mode_q;
    logic ready_q;
    logic res_valid_q;
    eld_result_t result_q;
    eld_result_t result_d;
    logic [15:0] dispatch_cnt_q;

    // Decode and check terms
    logic is_priv;
    logic is_user;
    logic bad_prefix;
    logic [31:0] leaf;
    logic [63:0] exit_map;
    logic [5:0] exit_idx;
    logic exit_hit;
    logic mode64;
    logic cap_ok;
    logic feature_ok;
    logic mode_ud;
    logic cfv_hit;

    eld_opcode_decode u_decode (
        .instr_i(instr_q),
        .is_priv_o(is_priv),
        .is_user_o(is_user),
        .bad_prefix_o(bad_prefix)
    );

    // A single-cycle access: ack follows one edge after the request
    assign acc_fire = wb_cyc_i & wb_stb_i & ~wb_ack_q;
    assign wr_fire = acc_fire & wb_we_i;

    // Acknowledge, dropped in the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
        end else begin
            wb_ack_q <= acc_fire;
        end
    end

    // Control and bitmap writes; settings only steer the next evaluation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `ELD_RST_CTRL;
            exit_lo_q <= `ELD_RST_EXIT;
            exit_hi_q <= `ELD_RST_EXIT;
            priv_leaves_q <= `ELD_RST_PRIV_LEAVES;
            user_leaves_q <= `ELD_RST_USER_LEAVES;
        end else if (wr_fire) begin
            unique case (wb_adr_i)
                `ELD_OFF_CTRL: ctrl_q <= wb_merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_000f;
                `ELD_OFF_EXIT_LO: exit_lo_q <= wb_merge(exit_lo_q, wb_dat_i, wb_sel_i);
                `ELD_OFF_EXIT_HI: exit_hi_q <= wb_merge(exit_hi_q, wb_dat_i, wb_sel_i);
                `ELD_OFF_PRIV_LEAVES: begin
                    priv_leaves_q <= wb_merge(priv_leaves_q, wb_dat_i, wb_sel_i);
                end
                `ELD_OFF_USER_LEAVES: begin
                    user_leaves_q <= wb_merge(user_leaves_q, wb_dat_i, wb_sel_i);
                end
                default: begin
                    // Status is read-only and unmapped writes are dropped
                end
            endcase
        end
    end

    // Read mux; unmapped offsets answer zero so the bus never hangs
    always_comb begin
        rd_data_d = 32'h0000_0000;
        unique case (wb_adr_i)
            `ELD_OFF_CTRL: rd_data_d = ctrl_q;
            `ELD_OFF_EXIT_LO: rd_data_d = exit_lo_q;
            `ELD_OFF_EXIT_HI: rd_data_d = exit_hi_q;
            `ELD_OFF_PRIV_LEAVES: rd_data_d = priv_leaves_q;
            `ELD_OFF_USER_LEAVES: rd_data_d = user_leaves_q;
            `ELD_OFF_STATUS: rd_data_d = status_q;
            default: rd_data_d = 32'h0000_0000;
        endcase
    end

    // Read data is registered together with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_q <= 32'h0000_0000;
        end else if (acc_fire && !wb_we_i) begin
            wb_dat_q <= rd_data_d;
        end
    end

    // State machine: one cycle to capture, one to evaluate
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ELD_ST_IDLE: begin
                if (req_valid_i) begin
                    state_d = ELD_ST_EVAL;
                end
            end
            ELD_ST_EVAL: state_d = ELD_ST_IDLE;
        endcase
    end

    // Ready is registered; it drops for the one evaluation cycle only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ELD_ST_IDLE;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == ELD_ST_IDLE);
        end
    end

    // Capture the instruction and machine state when a request is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_q <= '0;
            mode_q <= '0;
        end else if (req_valid_i && state_q == ELD_ST_IDLE) begin
            instr_q <= instr_i;
            mode_q <= mode_i;
        end
    end

    // Shared check terms
    // Checks read only the captured copies, never the live request ports
    assign leaf = instr_q.wide_accumulator[31:0];
    assign mode64 = in_64bit(mode_q);
    assign cap_ok = ctrl_q[`ELD_CTRL_CAP_BIT];
    assign feature_ok = ctrl_q[`ELD_CTRL_LOCK_BIT] & ctrl_q[`ELD_CTRL_ENABLE_BIT];
    assign exit_map = {exit_hi_q, exit_lo_q};

    // Leaves past the last direct index all fold onto the shared top bit
    assign exit_idx = (leaf > `ELD_EXIT_LAST_DIRECT) ? `ELD_EXIT_SHARED_BIT : leaf[5:0];
    assign exit_hit = exit_map[exit_idx];

    // Mode checks common to both instructions, prefixes included
    // Prefix faults share the mode group, so they rank after the abort
    assign mode_ud = bad_prefix | ~mode_q.protected_mode_enable | mode_q.virtual_8086_flag |
                     mode_q.system_management_state | ~cap_ok;

    // Marker wait is forgiven only for a resume at user level with TS and SMM clear and the capability bit set
    assign cfv_hit = mode_q.branch_tracking_en & mode_q.awaiting_branch_marker &
                     ((leaf != `ELD_LEAF_RESUME) | mode_q.task_switched_flag |
                      mode_q.system_management_state | ~cap_ok |
                      (mode_q.current_privilege_level != `ELD_CPL_USER));

    // Ordered checks; the first failing one decides the single outcome
    always_comb begin
        result_d = '0;
        result_d.kind = ELD_KIND_NONE;
        result_d.is_user = is_user;
        result_d.wide_mode = mode64;
        result_d.leaf = leaf;
        result_d.error_code = 16'h0000;
        if (!is_priv && !is_user) begin
            result_d.kind = ELD_KIND_NONE;
        end else if (mode_q.transaction_active) begin
            result_d.kind = ELD_KIND_ABORT;
        end else if (is_user && cfv_hit) begin
            result_d.kind = ELD_KIND_CFV;
        end else if (mode_ud) begin
            result_d.kind = ELD_KIND_UD;
        end else if (is_priv) begin
            if (mode_q.current_privilege_level != `ELD_CPL_KERNEL) begin
                result_d.kind = ELD_KIND_UD;
            end else if (mode_q.guest_mode && ctrl_q[`ELD_CTRL_EXIT_EN_BIT] && exit_hit) begin
                result_d.kind = ELD_KIND_VMEXIT;
            end else if (!feature_ok) begin
                result_d.kind = ELD_KIND_GP;
            end else if (!leaf_in(leaf, priv_leaves_q)) begin
                result_d.kind = ELD_KIND_GP;
            end else if (!mode_q.paging_enable) begin
                result_d.kind = ELD_KIND_GP;
            end else if (!mode64 && mode_q.ds_expand_down) begin
                result_d.kind = ELD_KIND_GP;
            end else begin
                result_d.kind = ELD_KIND_DISPATCH;
            end
        end else begin
            if (mode_q.task_switched_flag) begin
                result_d.kind = ELD_KIND_NM;
            end else if (mode_q.current_privilege_level != `ELD_CPL_USER) begin
                result_d.kind = ELD_KIND_UD;
            end else if (!feature_ok) begin
                result_d.kind = ELD_KIND_GP;
            end else if (!leaf_in(leaf, user_leaves_q)) begin
                result_d.kind = ELD_KIND_GP;
            end else if (!mode_q.paging_enable || !mode_q.native_fp_error_enable) begin
                result_d.kind = ELD_KIND_GP;
            end else if (!mode64 && !mode_q.cs_default_size) begin
                result_d.kind = ELD_KIND_GP;
            end else if (mode_q.inside_enclave_flag && leaf_in(leaf, `ELD_LEAF_ENTRY_MASK)) begin
                result_d.kind = ELD_KIND_GP;
            end else if (!mode_q.inside_enclave_flag &&
                         leaf_in(leaf, `ELD_LEAF_INSIDE_MASK)) begin
                result_d.kind = ELD_KIND_GP;
            end else begin
                result_d.kind = ELD_KIND_DISPATCH;
            end
        end
    end

    // One outcome pulse per taken request
    // A non-matching opcode still pulses, with kind none, so no request is lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_valid_q <= 1'b0;
            result_q <= '0;
        end else begin
            res_valid_q <= (state_q == ELD_ST_EVAL);
            if (state_q == ELD_ST_EVAL) begin
                result_q <= result_d;
            end
        end
    end

    // Status shows the last outcome, its leaf and a wrapping dispatch count
    // The count wraps silently; software must sample it often enough
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dispatch_cnt_q <= 16'h0000;
            status_q <= 32'h0000_0000;
        end else if (state_q == ELD_ST_EVAL) begin
            if (result_d.kind == ELD_KIND_DISPATCH) begin
                dispatch_cnt_q <= dispatch_cnt_q + 16'h0001;
            end
            status_q <= {((result_d.kind == ELD_KIND_DISPATCH) ?
                          (dispatch_cnt_q + 16'h0001) : dispatch_cnt_q),
                         leaf[7:0], 5'h00, result_d.kind};
        end
    end

    // Ports come straight from flops so delivery never sees a glitch
    assign wb_dat_o = wb_dat_q;
    assign wb_ack_o = wb_ack_q;
    assign req_ready_o = ready_q;
    assign res_valid_o = res_valid_q;
    assign result_o = result_q;
endmodule

// *** core/eld_map.svh ***
// Constants of the enclave leaf dispatch check: register offsets, field
// positions, reset values and instruction encodings.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef ELD_MAP_SVH
`define ELD_MAP_SVH

// Register byte offsets on the Wishbone slave
`define ELD_OFF_CTRL 8'h00
`define ELD_OFF_EXIT_LO 8'h04
`define ELD_OFF_EXIT_HI 8'h08
`define ELD_OFF_PRIV_LEAVES 8'h0c
`define ELD_OFF_USER_LEAVES 8'h10
`define ELD_OFF_STATUS 8'h14

// Control register fields
`define ELD_CTRL_CAP_BIT 0
`define ELD_CTRL_LOCK_BIT 1
`define ELD_CTRL_ENABLE_BIT 2
`define ELD_CTRL_EXIT_EN_BIT 3

// Reset values
`define ELD_RST_CTRL 32'h0000_0007
`define ELD_RST_EXIT 32'h0000_0000
`define ELD_RST_PRIV_LEAVES 32'h0000_ffff
`define ELD_RST_USER_LEAVES 32'h0000_02ff

// Opcode bytes
`define ELD_OP_ESC 8'h0f
`define ELD_OP_GRP 8'h01
`define ELD_OP_PRIV 8'hcf
`define ELD_OP_USER 8'hd7

// Privilege levels
`define ELD_CPL_KERNEL 2'h0
`define ELD_CPL_USER 2'h3

// Leaf numbers and leaf classes
`define ELD_LEAF_RESUME 32'h0000_0003
`define ELD_LEAF_ENTRY_MASK 32'h0000_000c
`define ELD_LEAF_INSIDE_MASK 32'h0000_02f3
`define ELD_LEAF_LIMIT 32'h0000_0020

// Exit bitmap: leaves above the last direct index share the top bit
`define ELD_EXIT_LAST_DIRECT 32'h0000_003e
`define ELD_EXIT_SHARED_BIT 6'h3f

`endif

// *** core/eld_opcode_decode.sv ***
// Opcode and prefix decoder for the two enclave-management instructions.
// Assumes the caller hands over the three opcode bytes and prefix flags.
`timescale 1ns/10ps
`include "eld_map.svh"
module eld_opcode_decode (
    input wire eld_pkg::eld_instr_t instr_i,
    output logic is_priv_o,
    output logic is_user_o,
    output logic bad_prefix_o
);
    import eld_pkg::*;

    logic esc_match;

    // Shared two-byte escape of both opcodes
    assign esc_match = (instr_i.esc_byte == `ELD_OP_ESC) && (instr_i.grp_byte == `ELD_OP_GRP);

    // Third byte picks the instruction; no mandatory prefix is taken
    assign is_priv_o = esc_match && (instr_i.fn_byte == `ELD_OP_PRIV);
    assign is_user_o = esc_match && (instr_i.fn_byte == `ELD_OP_USER);

    // Segment, address-size and extension prefixes are simply not looked at
    assign bad_prefix_o = instr_i.pfx.lock_pfx | instr_i.pfx.opsize_pfx |
                          instr_i.pfx.rep_pfx | instr_i.pfx.vex_pfx;
endmodule

// *** core/eld_pkg.sv ***
// Types of the enclave leaf dispatch check.
// Assumes eld_map.svh holds every figure; this package holds shapes only.
package eld_pkg;

    // Outcome handed to exception delivery
    typedef enum logic [2:0] {
        ELD_KIND_NONE = 3'b000,
        ELD_KIND_ABORT = 3'b001,
        ELD_KIND_CFV = 3'b010,
        ELD_KIND_UD = 3'b011,
        ELD_KIND_NM = 3'b100,
        ELD_KIND_VMEXIT = 3'b101,
        ELD_KIND_GP = 3'b110,
        ELD_KIND_DISPATCH = 3'b111
    } eld_kind_t;

    typedef enum logic {
        ELD_ST_IDLE = 1'b0,
        ELD_ST_EVAL = 1'b1
    } eld_state_t;

    typedef struct packed {
        logic lock_pfx;
        logic opsize_pfx;
        logic rep_pfx;
        logic vex_pfx;
        logic seg_override_pfx;
        logic addr_override_pfx;
        logic register_extension_prefix;
    } eld_prefix_t;

    typedef struct packed {
        logic [7:0] esc_byte;
        logic [7:0] grp_byte;
        logic [7:0] fn_byte;
        eld_prefix_t pfx;
        logic [63:0] wide_accumulator;
    } eld_instr_t;

    typedef struct packed {
        logic protected_mode_enable;
        logic virtual_8086_flag;
        logic system_management_state;
        logic [1:0] current_privilege_level;
        logic paging_enable;
        logic native_fp_error_enable;
        logic task_switched_flag;
        logic long_mode_active;
        logic cs_long;
        logic cs_default_size;
        logic ds_expand_down;
        logic inside_enclave_flag;
        logic guest_mode;
        logic transaction_active;
        logic branch_tracking_en;
        logic awaiting_branch_marker;
    } eld_mode_t;

    typedef struct packed {
        eld_kind_t kind;
        logic is_user;
        logic wide_mode;
        logic [31:0] leaf;
        logic [15:0] error_code;
    } eld_result_t;

endpackage

// *** tb/eld_check_assertions.sv ***
// Port checks of the enclave leaf dispatch check.
// Assumes a bind onto eld_dispatch_check; one clock domain.
`timescale 1ns/10ps
module eld_check_assertions
    import eld_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic req_valid_i,
    input wire eld_instr_t instr_i,
    input wire eld_mode_t mode_i,
    input wire logic req_ready_o,
    input wire logic res_valid_o,
    input wire eld_result_t result_o
);
    logic take;
    logic op_ok;
    logic priv_op;
    logic encl_op;
    // Decoded request at the take edge
    assign take = req_valid_i && req_ready_o;
    assign op_ok = instr_i.esc_byte == 8'h0f && instr_i.grp_byte == 8'h01;
    assign priv_op = op_ok && instr_i.fn_byte == 8'hcf;
    assign encl_op = priv_op || (op_ok && instr_i.fn_byte == 8'hd7);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_res_latency: assert property (take |=> !req_ready_o ##1 res_valid_o)
        else $error("outcome late");
    a_res_pulse: assert property (res_valid_o |=> !res_valid_o)
        else $error("pulse long");
    a_res_cause: assert property (res_valid_o |-> $past(take, 2))
        else $error("outcome without request");
    a_result_hold: assert property (!res_valid_o |-> $stable(result_o))
        else $error("result moved");
    a_leaf_low: assert property (take |-> ##2
        result_o.leaf == $past(instr_i.wide_accumulator[31:0], 2))
        else $error("leaf wrong");
    a_error_zero: assert property (res_valid_o |-> result_o.error_code == 16'h0)
        else $error("error code not zero");
    a_abort_first: assert property (take && encl_op && mode_i.transaction_active |->
        ##2 result_o.kind == ELD_KIND_ABORT) else $error("abort missing");
    a_prefix_ud: assert property (take && priv_op && !mode_i.transaction_active &&
        instr_i.pfx.lock_pfx |-> ##2 result_o.kind == ELD_KIND_UD)
        else $error("prefix accepted");
    a_priv_level: assert property (take && priv_op && !mode_i.transaction_active &&
        mode_i.current_privilege_level != 2'h0 |-> ##2 result_o.kind == ELD_KIND_UD)
        else $error("level accepted");
    c_dispatch: cover property (res_valid_o && result_o.kind == ELD_KIND_DISPATCH);
    c_exit: cover property (res_valid_o && result_o.kind == ELD_KIND_VMEXIT);
    c_flow: cover property (res_valid_o && result_o.kind == ELD_KIND_CFV);
endmodule

// *** tb/eld_dispatch_check_tb.sv ***
// Self-checking bench: random instructions against a rule model.
// Assumes core/ on the include path; classic Wishbone register access.
`timescale 1ns/10ps
module eld_dispatch_check_tb;
    import eld_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic req_valid_i = 1'b0;
    eld_instr_t instr_i = '0;
    eld_mode_t mode_i = '0;
    logic req_ready_o;
    logic res_valid_o;
    eld_result_t result_o;
    logic [31:0] sink_count;
    logic [31:0] ctrl = 32'h7;
    logic [31:0] pleaves = 32'hffff;
    logic [31:0] uleaves = 32'h2ff;
    logic [63:0] bm = 64'h0;
    eld_kind_t last_kind;
    logic [31:0] last_leaf;
    int errors = 0;
    int n_compared = 0;
    int seed = 89595;
    int n_req = 0;
    int n_disp = 0;

    eld_dispatch_check i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .req_valid_i(req_valid_i), .instr_i(instr_i), .mode_i(mode_i),
        .req_ready_o(req_ready_o), .res_valid_o(res_valid_o), .result_o(result_o));
    eld_exc_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .res_valid_i(res_valid_o),
        .result_i(result_o), .count_o(sink_count));

    // Free-running core clock, 50 ns period
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Outcome predicted from the machine state; first failing check wins
    function automatic eld_kind_t model(input eld_instr_t in, input eld_mode_t m);
        logic [31:0] lf;
        logic pr;
        logic us;
        logic ud;
        logic w64;
        lf = in.wide_accumulator[31:0];
        pr = in.esc_byte == 8'h0f && in.grp_byte == 8'h01 && in.fn_byte == 8'hcf;
        us = in.esc_byte == 8'h0f && in.grp_byte == 8'h01 && in.fn_byte == 8'hd7;
        w64 = m.long_mode_active && m.cs_long;
        ud = !m.protected_mode_enable || m.virtual_8086_flag || m.system_management_state
            || !ctrl[0] || in.pfx.lock_pfx || in.pfx.opsize_pfx || in.pfx.rep_pfx
            || in.pfx.vex_pfx;
        if (!pr && !us) return ELD_KIND_NONE;
        if (m.transaction_active) return ELD_KIND_ABORT;
        if (us && m.branch_tracking_en && m.awaiting_branch_marker && !(lf == 32'h3
            && !m.task_switched_flag && !m.system_management_state && ctrl[0]
            && m.current_privilege_level == 2'h3)) return ELD_KIND_CFV;
        if (ud) return ELD_KIND_UD;
        if (us && m.task_switched_flag) return ELD_KIND_NM;
        if (m.current_privilege_level != (us ? 2'h3 : 2'h0)) return ELD_KIND_UD;
        if (pr && m.guest_mode && ctrl[3] && bm[lf > 62 ? 6'h3f : lf[5:0]])
            return ELD_KIND_VMEXIT;
        if (!ctrl[1] || !ctrl[2]) return ELD_KIND_GP;
        if (lf > 31 || !(us ? uleaves[lf[4:0]] : pleaves[lf[4:0]])) return ELD_KIND_GP;
        if (!m.paging_enable || (us && !m.native_fp_error_enable)) return ELD_KIND_GP;
        if (!w64 && (us ? !m.cs_default_size : m.ds_expand_down))
            return ELD_KIND_GP;
        if (us && m.inside_enclave_flag && lf inside {2, 3}) return ELD_KIND_GP;
        if (us && !m.inside_enclave_flag && lf inside {0, 1, 4, 5, 6, 7, 9})
            return ELD_KIND_GP;
        return ELD_KIND_DISPATCH;
    endfunction

    // One classic Wishbone access; request held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            errors++;
            wrap_up();
        end
    endtask

    // One instruction through decode, compared with the model
    task automatic run_req(input eld_instr_t in, input eld_mode_t m);
        eld_kind_t k;
        int n;
        k = model(in, m);
        @(posedge clk_i);
        instr_i <= in;
        mode_i <= m;
        req_valid_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < 20);
        req_valid_i <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (res_valid_o !== 1'b1 && n < 40);
        if (n >= 40) begin
            errors++;
            wrap_up();
        end
        check(32'(result_o.kind), 32'(k), "kind");
        check(result_o.leaf, in.wide_accumulator[31:0], "leaf");
        if (k != ELD_KIND_NONE) begin
            check(32'(result_o.is_user), 32'(in.fn_byte == 8'hd7), "user");
            check(32'(result_o.wide_mode), 32'(m.long_mode_active & m.cs_long), "wide");
            n_req++;
        end
        // Status follows every outcome, a non-matching opcode included
        last_kind = k;
        last_leaf = in.wide_accumulator[31:0];
        if (k == ELD_KIND_DISPATCH) n_disp++;
    endtask

    initial begin
        logic [31:0] rd;
        logic [31:0] r;
        logic [31:0] r2;
        logic [31:0] mask;
        logic [31:0] rv [8];
        eld_instr_t in;
        eld_mode_t base;
        rv = '{32'h7, 32'h0, 32'h0, 32'hffff, 32'h2ff, 32'h0, 32'h0, 32'h0};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, then status and unmapped writes that must not stick
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0, rd);
            check(rd, rv[i], "reset value");
        end
        wb(1'b1, 8'h14, 32'hffffffff, rd);
        wb(1'b1, 8'h18, 32'hffffffff, rd);
        wb(1'b0, 8'h14, 32'h0, rd);
        check(rd, 32'h0, "status write");
        wb(1'b0, 8'h18, 32'h0, rd);
        check(rd, 32'h0, "unmapped");
        $display("test registers done");
        // Random instructions over occasionally rewritten settings
        for (int i = 0; i < 500; i++) begin
            if (i % 50 == 0) begin
                r = $random(seed);
                ctrl = {28'h0, r[12], 3'h7 ^ (r[2:0] & r[6:4])};
                bm = {32'($random(seed)), 32'($random(seed))};
                pleaves = $random(seed) | 32'hffff;
                uleaves = $random(seed) | 32'h2ff;
                wb(1'b1, 8'h00, ctrl, rd);
                wb(1'b1, 8'h04, bm[31:0], rd);
                wb(1'b1, 8'h08, bm[63:32], rd);
                wb(1'b1, 8'h0c, pleaves, rd);
                wb(1'b1, 8'h10, uleaves, rd);
                wb(1'b0, 8'h00, 32'h0, rd);
                check(rd, ctrl, "ctrl readback");
            end
            r = $random(seed);
            r2 = $random(seed);
            mask = $random(seed) & $random(seed) & $random(seed) & $random(seed);
            in.esc_byte = 8'h0f;
            in.grp_byte = 8'h01;
            in.fn_byte = r[1:0] == 2'h3 ? r[31:24] : (r[1:0] == 2'h2 ? 8'hd7 : 8'hcf);
            in.pfx = r[8:2] & r[15:9] & r[22:16] & r[29:23];
            in.wide_accumulator[63:32] = $random(seed);
            in.wide_accumulator[31:0] = r2[3:0] == 4'h0 ? 32'd59 + r2[7:4]
                : (r2[3:0] == 4'h1 ? r2 : {27'h0, r2[8:4]});
            base = '{1'b1, 1'b0, 1'b0, (r[1:0] == 2'h2 ? 2'h3 : 2'h0), 1'b1, 1'b1, 1'b0,
                1'b1, 1'b1, 1'b1, 1'b0, r2[9], r2[10], 1'b0, r2[11], 1'b0};
            run_req(in, base ^ mask[16:0]);
        end
        $display("test random done");
        wb(1'b0, 8'h14, 32'h0, rd);
        check({29'h0, rd[2:0]}, 32'(last_kind), "status kind");
        check({24'h0, rd[15:8]}, {24'h0, last_leaf[7:0]}, "status leaf");
        check({16'h0, rd[31:16]}, 32'(n_disp & 16'hffff), "dispatch count");
        check(sink_count, 32'(n_req), "delivered");
        $display("test status done");
        wrap_up();
    end
endmodule

bind eld_dispatch_check eld_check_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .req_valid_i(req_valid_i), .instr_i(instr_i), .mode_i(mode_i),
    .req_ready_o(req_ready_o), .res_valid_o(res_valid_o), .result_o(result_o));

// *** tb/eld_exc_sink.sv ***
// Exception delivery stand-in: counts outcomes of a kind other than none from the check block.
// Assumes one outcome pulse per taken instruction.
`timescale 1ns/10ps
module eld_exc_sink
    import eld_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic res_valid_i,
    input wire eld_result_t result_i,
    output logic [31:0] count_o
);
    // Every pulse of a kind other than none is one delivered outcome
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 32'h0;
        end else if (res_valid_i && result_i.kind != ELD_KIND_NONE) begin
            count_o <= count_o + 32'h1;
        end
    end
endmodule
